// [include/fsg_pkg.sv]
package fsg_pkg;
   localparam int CLK_HZ    = 10_000_000;
   localparam int DATA_LEN  = 8;
   localparam int IDX_W     = 4;
   localparam int BUF_BYTES = 1024;
   localparam int GAP_MS    = 20;
   localparam int GAP_CYC   = CLK_HZ / 1000 * GAP_MS;
   localparam int RST_MS    = 20;
   localparam int RST_CYC   = CLK_HZ / 1000 * RST_MS;

   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_OUT_LO = 8'h04;
   localparam logic [7:0] ADR_OUT_HI = 8'h08;
   localparam logic [7:0] ADR_MODE   = 8'h0c;
   localparam logic [7:0] ADR_STATUS = 8'h10;
   localparam logic [7:0] ADR_IN_LO  = 8'h14;
   localparam logic [7:0] ADR_IN_HI  = 8'h18;

   localparam int C0_CMD_MODE  = 0;
   localparam int C0_FRESH     = 7;
   localparam int C1_RACK      = 0;
   localparam int C1_SFB       = 2;
   localparam int C1_CTB       = 3;
   localparam int MODE_COLL    = 0;
   localparam int MODE_TLEN_LO = 8;
   localparam logic [3:0] TLEN_RST = 4'h8;

   localparam logic [7:0] RESET_PATTERN = 8'haa;
   localparam logic [7:0] ZERO_BYTE     = 8'h00;
   localparam logic [7:0] CTRL_LIMIT    = 8'h20;
   localparam logic [7:0] CH_STX        = 8'h02;
   localparam logic [7:0] CH_CR         = 8'h0d;
   localparam logic [7:0] CH_LF         = 8'h0a;
   // command character per bit of data byte 0, bit 7 first
   localparam logic [7:0][7:0] CMD_TABLE = {8'h50, 8'h52, 8'h48, 8'h43,
                                            8'h54, 8'h2d, 8'h2b, 8'h76};

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } fsg_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } fsg_wb_rsp_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } fsg_byte_t;

   typedef enum logic [2:0] {
      TX_IDLE   = 3'h0,
      TX_DIRECT = 3'h1,
      TX_APPEND = 3'h3,
      TX_DRAIN  = 3'h2,
      TX_CMD    = 3'h6
   } fsg_tx_state_t;
endpackage : fsg_pkg

// [rtl/fsg_byte_ram.sv]
module fsg_byte_ram #(
   parameter int DEPTH = fsg_pkg::BUF_BYTES,
   parameter int AW    = $clog2(DEPTH)
) (
   input  logic          core_clk_in,
   input  logic          wr_en_in,
   input  logic [AW-1:0] wr_addr_in,
   input  logic [7:0]    wr_data_in,
   input  logic [AW-1:0] rd_addr_in,
   output logic [7:0]    rd_data_out
);
   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
   } fsg_ram_state_t;

   fsg_ram_state_t s_r;
   fsg_ram_state_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (wr_en_in) begin
         s_nxt.mem[wr_addr_in] = wr_data_in;
      end
   end

   always_ff @(posedge core_clk_in) begin
      s_r <= s_nxt;
   end

   assign rd_data_out = s_r.mem[rd_addr_in];
endmodule : fsg_byte_ram

// [rtl/fsg_reset_qual.sv]
module fsg_reset_qual #(
   parameter int CYCLES = fsg_pkg::RST_CYC,
   parameter int CW     = $clog2(CYCLES + 1)
) (
   input  logic core_clk_in,
   input  logic resetn_in,
   input  logic match_in,
   output logic fire_out
);
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          done;
      logic          fire;
   } fsg_qual_state_t;

   fsg_qual_state_t s_r;
   fsg_qual_state_t s_nxt;

   always_comb begin
      s_nxt      = s_r;
      s_nxt.fire = 1'b0;
      if (!match_in) begin
         s_nxt.cnt  = '0; // RULE23
         s_nxt.done = 1'b0;
      end else if (s_r.cnt != CW'(CYCLES)) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (!s_r.done) begin
         s_nxt.fire = 1'b1; // RULE5
         s_nxt.done = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign fire_out = s_r.fire;
endmodule : fsg_reset_qual

// [rtl/fsg_gateway.sv]
// What the document requires
// RULE1: send-from-buffer toggle transmits whole buffer
// RULE2: copy-to-buffer toggle appends output data
// RULE3: controller toggles copy before send
// RULE4: unbuffered output data goes straight out
// RULE5: held AAh pattern clears buffers and bits
// RULE6: transparent mode passes one cycle, drops rest
// RULE7: device leaves gap over 20 ms
// RULE8: transparent telegram ends at first zero
// RULE9: collective mode buffers data, raises ready flag
// RULE10: collective mode keeps framing characters
// RULE11: buffer holds 1 kByte
// RULE12: short framed telegram bypasses the buffer
// RULE13: buffered data released only by acknowledge
// RULE14: controller toggles acknowledge once when empty
// RULE15: each acknowledge presents next block
// RULE16: buffer drains in arrival order
// RULE17: buffer empty after draining
// RULE18: command mode sends no output data
// RULE19: set bits send framed serial commands
// RULE20: command answers reach controller immediately
// RULE21: controller opens gate 2B, closes 2D
// RULE22: acknowledge change loads data, toggles loaded bit
// RULE23: pattern must hold unbroken whole interval
//
// The placing of the registers and the Wishbone register port were chosen for this implementation.
module fsg_gateway #(
   parameter int GAP_CYCLES   = fsg_pkg::GAP_CYC,
   parameter int RESET_CYCLES = fsg_pkg::RST_CYC,
   parameter int BUF_BYTES    = fsg_pkg::BUF_BYTES
) (
   input  logic                core_clk_in,
   input  logic                resetn_in,
   input  fsg_pkg::fsg_wb_req_t wb_req_in,
   output fsg_pkg::fsg_wb_rsp_t wb_rsp_out,
   input  fsg_pkg::fsg_byte_t   ser_rx_in,
   output fsg_pkg::fsg_byte_t   ser_tx_out,
   input  logic                ser_tx_ready_in
);
   localparam int DL = fsg_pkg::DATA_LEN;
   localparam int IW = fsg_pkg::IDX_W;
   localparam int AW = $clog2(BUF_BYTES);
   localparam int GW = $clog2(GAP_CYCLES + 1);

   typedef struct packed {
      logic [7:0]            ctrl0;
      logic [7:0]            ctrl1;
      logic [DL-1:0][7:0]    out_data;
      logic [DL-1:0][7:0]    prev_data;
      logic [DL-1:0][7:0]    in_data;
      logic                  coll;
      logic [3:0]            tlen;
      logic                  last_ctb;
      logic                  last_sfb;
      logic                  last_ack;
      logic                  last_fresh;
      logic [7:0]            prev_cmd;
      logic [7:0]            cmd_pend;
      logic [1:0]            cmd_phase;
      logic                  wb_ack;
      logic [31:0]           wb_dat;
      fsg_pkg::fsg_tx_state_t tx_state;
      logic [IW-1:0]         tx_idx;
      logic                  pend_drain;
      logic                  tx_valid;
      logic [7:0]            tx_data;
      logic [AW-1:0]         txb_wp;
      logic [AW-1:0]         txb_rp;
      logic [AW:0]           txb_cnt;
      logic [AW-1:0]         rxb_wp;
      logic [AW-1:0]         rxb_rp;
      logic [AW:0]           rxb_cnt;
      logic [AW:0]           tel_len;
      logic                  ld_req;
      logic                  ld_busy;
      logic [IW-1:0]         ld_idx;
      logic [7:0]            ld_n;
      logic [7:0]            in_cnt;
      logic                  loaded_tgl;
      logic                  trunc;
      logic [IW-1:0]         rx_idx;
      logic [GW-1:0]         gap_cnt;
   } fsg_top_state_t;

   localparam fsg_top_state_t ST_RST = '{tlen: fsg_pkg::TLEN_RST,
                                         tx_state: fsg_pkg::TX_IDLE,
                                         default: '0};

   fsg_top_state_t s_r;
   fsg_top_state_t s_nxt;
   logic [7:0]     txb_rd;
   logic [7:0]     rxb_rd;
   logic           txb_we;
   logic           rxb_we;
   logic           pattern;
   logic           clear;
   logic           data_ready_flag;

   function automatic logic [31:0] merge(input logic [31:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_w;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = new_w[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic [IW-1:0] eff_len(input logic [3:0] tlen);
      if (tlen == 4'h0 || 32'(tlen) > DL) begin
         return IW'(DL);
      end
      return IW'(tlen);
   endfunction : eff_len

   function automatic logic [2:0] low_bit(input logic [7:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction : low_bit

   assign pattern = s_r.ctrl0 == fsg_pkg::RESET_PATTERN &&
                    s_r.ctrl1 == fsg_pkg::RESET_PATTERN &&
                    s_r.out_data[0] == fsg_pkg::RESET_PATTERN &&
                    s_r.out_data[1] == fsg_pkg::RESET_PATTERN;

   // ready when collective buffer holds unread data and no block load is requested or running
   assign data_ready_flag = s_r.coll && s_r.rxb_cnt != '0 &&
                            !s_r.ld_busy && !s_r.ld_req; // RULE9

   assign txb_we = s_r.tx_state == fsg_pkg::TX_APPEND &&
                   s_r.txb_cnt < (AW+1)'(BUF_BYTES);
   assign rxb_we = s_r.coll && ser_rx_in.valid &&
                   s_r.rxb_cnt < (AW+1)'(BUF_BYTES);

   always_comb begin
      logic [31:0] w;
      logic        req;
      logic        hold;
      logic        tpop;
      logic        rpop;
      logic        adv;
      logic [7:0]  pend;
      w     = 32'h0;
      tpop  = 1'b0;
      rpop  = 1'b0;
      pend  = 8'h0;
      s_nxt = s_r;
      s_nxt.wb_ack = 1'b0;
      adv = !s_r.tx_valid || ser_tx_ready_in;
      if (!s_r.ld_busy && s_r.ld_req) begin
         s_nxt.ld_req = 1'b0;
      end

      // register bus; image writes wait while transmitting
      req  = wb_req_in.cyc && wb_req_in.stb && !s_r.wb_ack;
      hold = wb_req_in.we && s_r.tx_state != fsg_pkg::TX_IDLE &&
             (wb_req_in.adr == fsg_pkg::ADR_CTRL ||
              wb_req_in.adr == fsg_pkg::ADR_OUT_LO ||
              wb_req_in.adr == fsg_pkg::ADR_OUT_HI);
      if (req && !hold) begin
         s_nxt.wb_ack = 1'b1;
         unique case (wb_req_in.adr)
            fsg_pkg::ADR_CTRL:   s_nxt.wb_dat = {16'h0, s_r.ctrl1, s_r.ctrl0};
            fsg_pkg::ADR_OUT_LO: s_nxt.wb_dat = s_r.out_data[3:0];
            fsg_pkg::ADR_OUT_HI: s_nxt.wb_dat = s_r.out_data[7:4];
            fsg_pkg::ADR_MODE:   s_nxt.wb_dat = {20'h0, s_r.tlen, 7'h0, s_r.coll};
            fsg_pkg::ADR_STATUS: s_nxt.wb_dat = {16'h0, s_r.in_cnt, 5'h0,
                                                 s_r.tx_state != fsg_pkg::TX_IDLE,
                                                 s_r.loaded_tgl, data_ready_flag};
            fsg_pkg::ADR_IN_LO:  s_nxt.wb_dat = s_r.in_data[3:0];
            fsg_pkg::ADR_IN_HI:  s_nxt.wb_dat = s_r.in_data[7:4];
            default:             s_nxt.wb_dat = 32'h0;
         endcase
         if (wb_req_in.we) begin
            unique case (wb_req_in.adr)
               fsg_pkg::ADR_OUT_LO: s_nxt.out_data[3:0] =
                  merge(s_r.out_data[3:0], wb_req_in.dat, wb_req_in.sel);
               fsg_pkg::ADR_OUT_HI: s_nxt.out_data[7:4] =
                  merge(s_r.out_data[7:4], wb_req_in.dat, wb_req_in.sel);
               fsg_pkg::ADR_MODE: begin
                  w = merge({20'h0, s_r.tlen, 7'h0, s_r.coll}, wb_req_in.dat,
                            wb_req_in.sel);
                  s_nxt.coll = w[fsg_pkg::MODE_COLL];
                  s_nxt.tlen = w[fsg_pkg::MODE_TLEN_LO +: 4];
               end
               fsg_pkg::ADR_CTRL: begin
                  // control word write marks one fieldbus output cycle
                  w = merge({16'h0, s_r.ctrl1, s_r.ctrl0}, wb_req_in.dat,
                            wb_req_in.sel);
                  s_nxt.ctrl0      = w[7:0];
                  s_nxt.ctrl1      = w[15:8];
                  s_nxt.last_ctb   = w[8 + fsg_pkg::C1_CTB];
                  s_nxt.last_sfb   = w[8 + fsg_pkg::C1_SFB];
                  s_nxt.last_ack   = w[8 + fsg_pkg::C1_RACK];
                  s_nxt.last_fresh = w[fsg_pkg::C0_FRESH];
                  s_nxt.prev_data  = s_r.out_data;
                  s_nxt.tx_idx     = '0;
                  s_nxt.cmd_phase  = 2'h0;
                  if (s_r.coll && w[8 + fsg_pkg::C1_RACK] != s_r.last_ack) begin
                     s_nxt.ld_req = 1'b1; // RULE22 RULE14 RULE15
                  end
                  if (w[fsg_pkg::C0_CMD_MODE]) begin
                     // RULE18
                     pend = s_r.out_data[0] & ~s_r.prev_cmd;
                     s_nxt.prev_cmd = s_r.out_data[0];
                     s_nxt.cmd_pend = pend;
                     if (pend != 8'h0) begin
                        s_nxt.tx_state = fsg_pkg::TX_CMD; // RULE19 RULE21
                     end
                  end else if (w[8 + fsg_pkg::C1_CTB] != s_r.last_ctb) begin
                     s_nxt.tx_state   = fsg_pkg::TX_APPEND; // RULE2
                     s_nxt.pend_drain = w[8 + fsg_pkg::C1_SFB] != s_r.last_sfb; // RULE3
                  end else if (w[8 + fsg_pkg::C1_SFB] != s_r.last_sfb) begin
                     s_nxt.tx_state = fsg_pkg::TX_DRAIN; // RULE1
                  end else if (s_r.out_data != s_r.prev_data ||
                               w[fsg_pkg::C0_FRESH] != s_r.last_fresh) begin
                     s_nxt.tx_state = fsg_pkg::TX_DIRECT; // RULE4
                  end
               end
               default: ;
            endcase
         end
      end

      // serial transmit engine
      unique case (s_r.tx_state)
         fsg_pkg::TX_IDLE: ;
         fsg_pkg::TX_APPEND: begin
            if (txb_we) begin
               s_nxt.txb_wp = s_r.txb_wp + 1'b1;
            end
            if (s_r.tx_idx == eff_len(s_r.tlen) - 1'b1) begin
               s_nxt.tx_state = s_r.pend_drain ? fsg_pkg::TX_DRAIN : fsg_pkg::TX_IDLE;
               s_nxt.pend_drain = 1'b0;
            end else begin
               s_nxt.tx_idx = s_r.tx_idx + 1'b1;
            end
         end
         fsg_pkg::TX_DIRECT: begin
            if (adv) begin
               if (s_r.tx_idx < eff_len(s_r.tlen)) begin
                  s_nxt.tx_data  = s_r.out_data[s_r.tx_idx]; // RULE4
                  s_nxt.tx_valid = 1'b1;
                  s_nxt.tx_idx   = s_r.tx_idx + 1'b1;
               end else begin
                  s_nxt.tx_valid = 1'b0;
                  s_nxt.tx_state = fsg_pkg::TX_IDLE;
               end
            end
         end
         fsg_pkg::TX_DRAIN: begin
            if (adv) begin
               if (s_r.txb_cnt != '0) begin
                  s_nxt.tx_data  = txb_rd; // RULE16
                  s_nxt.tx_valid = 1'b1;
                  s_nxt.txb_rp   = s_r.txb_rp + 1'b1;
                  tpop           = 1'b1;
               end else begin
                  s_nxt.tx_valid = 1'b0; // RULE17
                  s_nxt.tx_state = fsg_pkg::TX_IDLE;
               end
            end
         end
         fsg_pkg::TX_CMD: begin
            if (adv) begin
               if (s_r.cmd_pend != 8'h0) begin
                  s_nxt.tx_valid  = 1'b1;
                  s_nxt.cmd_phase = s_r.cmd_phase + 1'b1;
                  unique case (s_r.cmd_phase) // RULE19
                     2'h0: s_nxt.tx_data = fsg_pkg::CH_STX;
                     2'h1: s_nxt.tx_data = fsg_pkg::CMD_TABLE[low_bit(s_r.cmd_pend)];
                     2'h2: s_nxt.tx_data = fsg_pkg::CH_CR;
                     2'h3: begin
                        s_nxt.tx_data  = fsg_pkg::CH_LF;
                        s_nxt.cmd_pend = s_r.cmd_pend & (s_r.cmd_pend - 1'b1);
                     end
                  endcase
               end else begin
                  s_nxt.tx_valid = 1'b0;
                  s_nxt.tx_state = fsg_pkg::TX_IDLE;
               end
            end
         end
         default: begin
            s_nxt.tx_valid = 1'b0;
            s_nxt.tx_state = fsg_pkg::TX_IDLE;
         end
      endcase

      // receive side
      if (ser_rx_in.valid) begin
         s_nxt.gap_cnt = '0;
      end else if (s_r.gap_cnt != GW'(GAP_CYCLES)) begin
         s_nxt.gap_cnt = s_r.gap_cnt + 1'b1;
      end
      if (ser_rx_in.valid && !s_r.coll) begin
         if (s_r.gap_cnt == GW'(GAP_CYCLES)) begin
            s_nxt.in_data    = '0; // RULE7
            s_nxt.rx_idx     = '0;
            s_nxt.in_cnt     = 8'h0;
            s_nxt.trunc      = 1'b0;
            s_nxt.loaded_tgl = ~s_r.loaded_tgl;
         end
         if (ser_rx_in.data == fsg_pkg::ZERO_BYTE) begin
            s_nxt.trunc = 1'b1; // RULE8
         end else if (ser_rx_in.data >= fsg_pkg::CTRL_LIMIT && !s_nxt.trunc &&
                      32'(s_nxt.rx_idx) < DL) begin
            s_nxt.in_data[s_nxt.rx_idx] = ser_rx_in.data; // RULE6
            s_nxt.rx_idx = s_nxt.rx_idx + 1'b1;
            s_nxt.in_cnt = 8'(s_nxt.rx_idx);
         end
      end
      if (ser_rx_in.valid && s_r.coll) begin
         if (rxb_we) begin
            s_nxt.rxb_wp = s_r.rxb_wp + 1'b1; // RULE9 RULE10
         end
         s_nxt.tel_len = s_r.tel_len + 1'b1;
         if (ser_rx_in.data == fsg_pkg::CH_LF) begin
            s_nxt.tel_len = '0;
            if (s_r.ctrl0[fsg_pkg::C0_CMD_MODE]) begin
               s_nxt.ld_req = 1'b1; // RULE20
            end else if (32'(s_r.tel_len) < DL && s_r.rxb_cnt == s_r.tel_len) begin
               s_nxt.ld_req = 1'b1; // RULE12
            end
         end
      end

      // block load into the input image
      if (!s_r.ld_busy && s_r.ld_req) begin
         s_nxt.ld_busy = 1'b1; // RULE13
         s_nxt.ld_idx  = '0;
         s_nxt.ld_n    = 8'h0;
      end
      if (s_r.ld_busy) begin
         if (s_r.rxb_cnt != '0) begin
            s_nxt.in_data[s_r.ld_idx] = rxb_rd; // RULE15
            s_nxt.rxb_rp = s_r.rxb_rp + 1'b1;
            s_nxt.ld_n   = s_r.ld_n + 1'b1;
            rpop         = 1'b1;
         end else begin
            s_nxt.in_data[s_r.ld_idx] = fsg_pkg::ZERO_BYTE;
         end
         if (32'(s_r.ld_idx) == DL - 1) begin
            s_nxt.ld_busy    = 1'b0;
            s_nxt.in_cnt     = s_nxt.ld_n;
            s_nxt.loaded_tgl = ~s_r.loaded_tgl; // RULE22
         end else begin
            s_nxt.ld_idx = s_r.ld_idx + 1'b1;
         end
      end

      s_nxt.txb_cnt = s_r.txb_cnt + {{AW{1'b0}}, txb_we} - {{AW{1'b0}}, tpop};
      s_nxt.rxb_cnt = s_r.rxb_cnt + {{AW{1'b0}}, rxb_we} - {{AW{1'b0}}, rpop};

      if (clear) begin
         s_nxt.ctrl0      = 8'h0; // RULE5
         s_nxt.ctrl1      = 8'h0;
         s_nxt.last_ctb   = 1'b0;
         s_nxt.last_sfb   = 1'b0;
         s_nxt.last_ack   = 1'b0;
         s_nxt.last_fresh = 1'b0;
         s_nxt.prev_cmd   = 8'h0;
         s_nxt.cmd_pend   = 8'h0;
         s_nxt.pend_drain = 1'b0;
         s_nxt.tx_state   = fsg_pkg::TX_IDLE;
         s_nxt.tx_valid   = 1'b0;
         s_nxt.txb_wp     = '0;
         s_nxt.txb_rp     = '0;
         s_nxt.txb_cnt    = '0;
         s_nxt.rxb_wp     = '0;
         s_nxt.rxb_rp     = '0;
         s_nxt.rxb_cnt    = '0;
         s_nxt.tel_len    = '0;
         s_nxt.ld_req     = 1'b0;
         s_nxt.ld_busy    = 1'b0;
         s_nxt.in_data    = '0;
         s_nxt.in_cnt     = 8'h0;
         s_nxt.loaded_tgl = 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // RULE11
   fsg_byte_ram #(.DEPTH(BUF_BYTES), .AW(AW)) u_tx_buf (
      .core_clk_in (core_clk_in),
      .wr_en_in    (txb_we),
      .wr_addr_in  (s_r.txb_wp),
      .wr_data_in  (s_r.out_data[s_r.tx_idx]),
      .rd_addr_in  (s_r.txb_rp),
      .rd_data_out (txb_rd)
   );

   fsg_byte_ram #(.DEPTH(BUF_BYTES), .AW(AW)) u_rx_buf (
      .core_clk_in (core_clk_in),
      .wr_en_in    (rxb_we),
      .wr_addr_in  (s_r.rxb_wp),
      .wr_data_in  (ser_rx_in.data),
      .rd_addr_in  (s_r.rxb_rp),
      .rd_data_out (rxb_rd)
   );

   fsg_reset_qual #(.CYCLES(RESET_CYCLES)) u_reset_qual (
      .core_clk_in (core_clk_in),
      .resetn_in   (resetn_in),
      .match_in    (pattern),
      .fire_out    (clear)
   );

   assign wb_rsp_out = '{ack: s_r.wb_ack, dat: s_r.wb_dat};
   assign ser_tx_out = '{valid: s_r.tx_valid, data: s_r.tx_data};
endmodule : fsg_gateway

// [verification/fsg_serial_dev.sv]
module fsg_serial_dev (
   input  wire logic         core_clk_in,
   input  fsg_pkg::fsg_byte_t tx_in,
   input  wire logic         slow_in,
   output logic              ready_out,
   output fsg_pkg::fsg_byte_t rx_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt_r = 2'h0;
   logic [7:0] got[$];
   initial rx_out = '0;
   assign ready_out = !slow_in || cnt_r == 2'h0;
   always @(posedge core_clk_in) begin
      cnt_r <= cnt_r + 2'h1;
      if (tx_in.valid && ready_out) got.push_back(tx_in.data);
   end
   // quiet line, then one byte a cycle pair
   task send(input logic [7:0] b[$]);
      repeat (30) @(posedge core_clk_in);
      foreach (b[i]) begin
         @(posedge core_clk_in) rx_out <= '{1'b1, b[i]};
         @(posedge core_clk_in) rx_out <= '{1'b0, ~b[i]};
      end
   endtask : send
endmodule : fsg_serial_dev

// [verification/fsg_gateway_asserts.sv]
module fsg_gateway_asserts (
   input wire logic           core_clk_in,
   input wire logic           resetn_in,
   input fsg_pkg::fsg_wb_req_t wb_req_in,
   input fsg_pkg::fsg_wb_rsp_t wb_rsp_out,
   input fsg_pkg::fsg_byte_t   ser_tx_out,
   input wire logic           ser_tx_ready_in
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   sequence s_req;
      wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack;
   endsequence
   sequence s_rd(a);
      s_req ##0 (!wb_req_in.we && wb_req_in.adr == a);
   endsequence
   a_ack_pulse: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack)
      else $error("ack held too long");
   a_ack_cause: assert property (wb_rsp_out.ack |-> $past(wb_req_in.cyc && wb_req_in.stb))
      else $error("ack without request");
   a_read_quick: assert property (s_req ##0 !wb_req_in.we |=> wb_rsp_out.ack)
      else $error("read not answered next cycle");
   a_write_done: assert property (s_req ##0 wb_req_in.we |-> ##[1:1000] wb_rsp_out.ack)
      else $error("write never answered");
   a_unmapped_zero: assert property (s_rd(8'h40) |=> wb_rsp_out.dat == 32'h0)
      else $error("unmapped read not zero");
   a_status_upper: assert property (s_rd(fsg_pkg::ADR_STATUS) |=> wb_rsp_out.dat[31:16] == 16'h0)
      else $error("status upper bits set");
   a_mode_fields: assert property (s_rd(fsg_pkg::ADR_MODE)
      |=> wb_rsp_out.dat[31:12] == 20'h0 && wb_rsp_out.dat[7:1] == 7'h0)
      else $error("mode unused bits set");
   a_tx_hold: assert property (ser_tx_out.valid && !ser_tx_ready_in
      |=> ser_tx_out.valid && $stable(ser_tx_out.data))
      else $error("tx byte lost while stalled");
endmodule : fsg_gateway_asserts

// [verification/tb_top.sv]
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk;
   logic                 resetn = 1'b0;
   logic                 slow = 1'b0;
   logic                 rdy;
   logic [31:0]          rdat;
   int                   checks = 0;
   int                   miscompares = 0;
   fsg_pkg::fsg_wb_req_t req = '0;
   fsg_pkg::fsg_wb_rsp_t rsp;
   fsg_pkg::fsg_byte_t   rx;
   fsg_pkg::fsg_byte_t   tx;
   fsg_gateway #(.GAP_CYCLES(20), .RESET_CYCLES(16), .BUF_BYTES(1024)) i_dut (
      .core_clk_in(clk), .resetn_in(resetn), .wb_req_in(req), .wb_rsp_out(rsp),
      .ser_rx_in(rx), .ser_tx_out(tx), .ser_tx_ready_in(rdy));
   fsg_serial_dev i_dev (.core_clk_in(clk), .tx_in(tx), .slow_in(slow),
      .ready_out(rdy), .rx_out(rx));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task give_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk) req <= '{1'b1, 1'b1, w, a, 4'hf, d};
      do begin
         @(posedge clk);
         n++;
      end while (rsp.ack !== 1'b1 && n < 3000);
      if (rsp.ack !== 1'b1) begin
         miscompares++;
         give_verdict();
      end else begin
         rdat = rsp.dat;
         req <= '0;
      end
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e, input string s);
      bus(1'b0, a, 32'h0);
      chk(s, e, rdat);
   endtask : rd
   task wait_st(input logic [31:0] m, input logic [31:0] v);
      int n;
      for (n = 0; n < 200; n++) begin
         bus(1'b0, fsg_pkg::ADR_STATUS, 32'h0);
         if ((rdat & m) === v) break;
      end
      chk("status wait", v, rdat & m);
   endtask : wait_st
   task exp_tx(input logic [7:0] e[$]);
      chk("tx count", e.size(), i_dev.got.size());
      foreach (e[i]) chk("tx byte", e[i], i_dev.got[i]);
      i_dev.got.delete();
   endtask : exp_tx
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      rd(fsg_pkg::ADR_CTRL, 32'h0, "ctrl rst");
      rd(fsg_pkg::ADR_MODE, 32'h800, "mode rst");
      rd(fsg_pkg::ADR_STATUS, 32'h0, "status rst");
      rd(8'h40, 32'h0, "unmapped");
      $display("test reset done");
      wr(fsg_pkg::ADR_MODE, 32'h200);
      wr(fsg_pkg::ADR_OUT_LO, 32'h4241);
      wr(fsg_pkg::ADR_CTRL, 32'h0);
      wait_st(32'h4, 32'h0);
      exp_tx('{8'h41, 8'h42});
      $display("test direct done");
      wr(fsg_pkg::ADR_OUT_LO, 32'h3231);
      wr(fsg_pkg::ADR_CTRL, 32'h800);
      wr(fsg_pkg::ADR_OUT_LO, 32'h3433);
      wr(fsg_pkg::ADR_CTRL, 32'h0);
      chk("tx none", 0, i_dev.got.size());
      slow <= 1'b1;
      wr(fsg_pkg::ADR_CTRL, 32'h400);
      wait_st(32'h4, 32'h0);
      exp_tx('{8'h31, 8'h32, 8'h33, 8'h34});
      slow <= 1'b0;
      wr(fsg_pkg::ADR_CTRL, 32'h0);
      wait_st(32'h4, 32'h0);
      chk("tx left", 0, i_dev.got.size());
      $display("test buffer done");
      wr(fsg_pkg::ADR_OUT_LO, 32'h1);
      wr(fsg_pkg::ADR_CTRL, 32'h1);
      wait_st(32'h4, 32'h0);
      exp_tx('{8'h02, 8'h76, 8'h0d, 8'h0a});
      wr(fsg_pkg::ADR_OUT_LO, 32'h3);
      wr(fsg_pkg::ADR_CTRL, 32'h1);
      wait_st(32'h4, 32'h0);
      exp_tx('{8'h02, 8'h2b, 8'h0d, 8'h0a});
      $display("test command done");
      i_dev.send('{8'h41, 8'h42, 8'h00, 8'h43});
      rd(fsg_pkg::ADR_IN_LO, 32'h4241, "in cut");
      rd(fsg_pkg::ADR_STATUS, 32'h202, "rx status");
      $display("test transparent done");
      wr(fsg_pkg::ADR_OUT_LO, 32'haaaa);
      wr(fsg_pkg::ADR_CTRL, 32'haaaa);
      repeat (40) @(posedge clk);
      rd(fsg_pkg::ADR_CTRL, 32'h0, "ctrl clr");
      rd(fsg_pkg::ADR_STATUS, 32'h0, "status clr");
      $display("test clear done");
      wr(fsg_pkg::ADR_OUT_LO, 32'h0);
      wr(fsg_pkg::ADR_MODE, 32'h201);
      i_dev.send('{8'h02, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38,
                   8'h0d, 8'h0a});
      wait_st(32'h1, 32'h1);
      rd(fsg_pkg::ADR_IN_LO, 32'h0, "no push");
      wr(fsg_pkg::ADR_CTRL, 32'h100);
      wait_st(32'h2, 32'h2);
      rd(fsg_pkg::ADR_IN_LO, 32'h33323102, "blk lo");
      rd(fsg_pkg::ADR_IN_HI, 32'h37363534, "blk hi");
      rd(fsg_pkg::ADR_STATUS, 32'h803, "blk status");
      wr(fsg_pkg::ADR_CTRL, 32'h0);
      wait_st(32'h2, 32'h0);
      rd(fsg_pkg::ADR_IN_LO, 32'ha0d38, "tail lo");
      rd(fsg_pkg::ADR_STATUS, 32'h300, "tail status");
      wr(fsg_pkg::ADR_CTRL, 32'h100);
      wait_st(32'h2, 32'h2);
      rd(fsg_pkg::ADR_STATUS, 32'h2, "end status");
      $display("test collective done");
      give_verdict();
   end
endmodule : tb_top
bind fsg_gateway fsg_gateway_asserts i_chk (.core_clk_in, .resetn_in, .wb_req_in,
   .wb_rsp_out, .ser_tx_out, .ser_tx_ready_in);
